// [rtl/cls_clk_mux.sv]
// Glitch-free selector for the clock output
// Assumes each source divider runs only while it is the current source
`timescale 1ns/1ps
module cls_clk_mux
  import cls_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input cls_pkg::cls_src_t req,
  input wire logic norm_q,
  input wire logic slow_q,
  output cls_pkg::cls_src_t cur,
  output logic out
);
  wire sel_q = (cur == CLS_SRC_NORMAL) ? norm_q : (cur == CLS_SRC_SLOW) ? slow_q : 1'b0;
  wire quiet = !sel_q && !out;

  // Follow the current source; change source only while low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur <= CLS_SRC_OFF;
      out <= 1'b0;
    end else begin
      out <= sel_q;
      if (req != cur && quiet) begin
        cur <= req;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_switch_low: assert property ($changed(cur) |-> !$past(out) && !out)
    else $error("clock source changed while output high");
  a_off_static: assert property (cur == CLS_SRC_OFF ##1 cur == CLS_SRC_OFF |-> !out)
    else $error("clock output moved with no source selected");
endmodule

// [rtl/cls_div.sv]
// Clock divider producing a square wave from the system clock
// Assumes run and half come from logic on the same clock
`timescale 1ns/1ps
module cls_div #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [W-1:0] half,
  output logic q
);
  logic [W-1:0] cnt;
  wire [W-1:0] half_m1 = half - W'(1);
  wire last = (cnt >= half_m1);

  // Count half periods; idle low so a restart begins with a full low phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= '0;
      q <= 1'b0;
    end else if (!run) begin
      cnt <= '0;
      q <= 1'b0;
    end else if (last) begin
      cnt <= '0;
      q <= ~q;
    end else begin
      cnt <= cnt + W'(1);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_div_no_runt: assert property (run && $past(run) && $changed(q) |-> $past(last))
    else $error("divider output toggled before its half period");
  a_div_idle_low: assert property (!run |=> !q)
    else $error("stopped divider output not low");
endmodule

// [rtl/cls_map.svh]
// Constants of the clock-output and suspend control block
// Assumes inclusion by bare name from the package and the design files
`ifndef CLS_MAP_SVH
`define CLS_MAP_SVH

// Register byte offsets on the APB slave
`define CLS_HW_CFG_ADDR 12'h000
`define CLS_MODE_ADDR 12'h004
`define CLS_STATUS_ADDR 12'h008

// Field positions, configuration register
`define CLS_CFG_DIV_LSB 0
`define CLS_CFG_DIV_MSB 3
`define CLS_CFG_OSC_RUN_BIT 4
`define CLS_CFG_SLOW_DIS_BIT 5
// Field positions, mode and status registers
`define CLS_MODE_GO_SUSP_BIT 0
`define CLS_STAT_REF_BIT 0
`define CLS_STAT_BUS_SUSP_BIT 7

// Reset values
`define CLS_CFG_RESET 6'h13
`define CLS_MODE_RESET 1'h0

// Timing, figures in their own units
`define CLS_CLK_NS 40
`define CLS_SUSP_DELAY_US 2000
`define CLS_RESUME_DELAY_US 500
`define CLS_SLOW_HALF_NS 5000
`define CLS_REF_TIMEOUT_NS 2560

// Cycle counts derived from the figures, least times rounded up
`define CLS_SUSP_DELAY_CYC ((`CLS_SUSP_DELAY_US * 1000 + `CLS_CLK_NS - 1) / `CLS_CLK_NS)
`define CLS_RESUME_DELAY_CYC ((`CLS_RESUME_DELAY_US * 1000 + `CLS_CLK_NS - 1) / `CLS_CLK_NS)
`define CLS_SLOW_HALF_CYC ((`CLS_SLOW_HALF_NS + `CLS_CLK_NS - 1) / `CLS_CLK_NS)
`define CLS_REF_TIMEOUT_CYC ((`CLS_REF_TIMEOUT_NS + `CLS_CLK_NS - 1) / `CLS_CLK_NS)

`endif

// [rtl/cls_pkg.sv]
// Types of the clock-output and suspend control block
// Assumes the constants header is on the include path
package cls_pkg;
  `include "cls_map.svh"

  // Clock-output source
  typedef enum logic [1:0] {
    CLS_SRC_NORMAL = 2'h0,
    CLS_SRC_SLOW = 2'h1,
    CLS_SRC_OFF = 2'h3
  } cls_src_t;

  // Suspend sequence, Gray coded along the loop
  typedef enum logic [1:0] {
    CLS_AWAKE = 2'h0,
    CLS_ENTERING = 2'h1,
    CLS_SUSPENDED = 2'h3,
    CLS_RESUMING = 2'h2
  } cls_state_t;

  // Software configuration
  typedef struct packed {
    logic slow_clk_disable;
    logic osc_run;
    logic [3:0] clk_out_divider;
  } cls_cfg_t;
endpackage

// [rtl/cls_top.sv]
// Clock-output and suspend control with an APB register slave
// Assumes an APB master on clk; wake-up and reference pins are asynchronous
`timescale 1ns/1ps
`include "cls_map.svh"

// Behaviour
// - The reference input takes a crystal or an external square wave; osc_out is unused then.
// - The reference is multiplied to one internal high-rate clock by the PLL.
// - The clock output is derived from the PLL clock at a programmable rate.
// - The four-bit divider field sets the division of the normal clock output.
// - The oscillator-run bit turns the oscillator on when set and off when cleared.
// - In suspend the oscillator and PLL are off and the normal clock output stops.
// - The slow-clock-disable bit decides whether the slow clock drives the output in suspend.
// - With that bit clear the output keeps toggling in suspend at the slow rate.
// - The suspend output and clock output change about 2 ms after the request.
// - A positive wake pulse clears the suspend output; the clock restarts 0.5 ms later.
// - The bus suspend status bit reads zero when awake and one when suspended.
module cls_top
  import cls_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 17,
  parameter int SUSP_DELAY_CYC = `CLS_SUSP_DELAY_CYC,
  parameter int RESUME_DELAY_CYC = `CLS_RESUME_DELAY_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic osc_in,
  output logic osc_out,
  input wire logic dev_wake_in,
  output logic clock_output_pin,
  output logic dev_suspend,
  output logic osc_enable,
  output logic pll_enable
);
  import cls_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  cls_cfg_t dev_hw_config_reg;
  logic go_suspend;
  logic go_suspend_prev;
  cls_state_t state;
  cls_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic wake_s1;
  logic wake_s2;
  logic wake_s3;
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic [7:0] ref_timer;
  logic ref_active;
  cls_src_t req_src;
  cls_src_t cur_src;
  logic norm_q;
  logic slow_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Access phase, first cycle only; answer follows one cycle later
  wire access = psel && penable && !pready;
  wire hit_cfg = (paddr == ADDR_W'(`CLS_HW_CFG_ADDR));
  wire hit_mode = (paddr == ADDR_W'(`CLS_MODE_ADDR));
  wire hit_stat = (paddr == ADDR_W'(`CLS_STATUS_ADDR));
  wire hit_any = hit_cfg || hit_mode || hit_stat;
  wire wr_cfg = access && pwrite && hit_cfg;
  wire wr_mode = access && pwrite && hit_mode;
  wire rd_any = access && !pwrite;

  // Read data per register; unused bits read zero
  wire [31:0] rd_cfg = {26'h0, dev_hw_config_reg};
  wire [31:0] rd_mode = {31'h0, go_suspend};
  wire [31:0] rd_stat = {24'h0, dev_suspend, 6'h0, ref_active};
  wire [31:0] rd_mux = hit_cfg ? rd_cfg : hit_mode ? rd_mode : hit_stat ? rd_stat : 32'h0;

  // Bus answer registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= access;
      pslverr <= access && !hit_any;
      if (rd_any) begin
        prdata <= rd_mux;
      end
    end
  end

  // Software registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dev_hw_config_reg <= cls_cfg_t'(`CLS_CFG_RESET);
      go_suspend <= `CLS_MODE_RESET;
    end else begin
      if (wr_cfg) begin
        dev_hw_config_reg <= cls_cfg_t'(pwdata[5:0]);
      end
      if (wr_mode) begin
        go_suspend <= pwdata[`CLS_MODE_GO_SUSP_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Two flops before any logic; third stage only for edge detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      wake_s1 <= dev_wake_in;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
      osc_s1 <= osc_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // Edges seen on the synchronised pins
  wire wake_rise = wake_s2 && !wake_s3;
  wire osc_edge = osc_s2 != osc_s3;

  // Reference presence, crystal or external square wave alike
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_timer <= 8'h00;
      ref_active <= 1'b0;
    end else if (osc_edge) begin
      ref_timer <= 8'(`CLS_REF_TIMEOUT_CYC);
      ref_active <= 1'b1;
    end else if (ref_timer != 8'h00) begin
      ref_timer <= ref_timer - 8'h01;
    end else begin
      ref_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Suspend sequence

  // Request is the set-then-clear of go_suspend
  wire go_suspend_fall = go_suspend_prev && !go_suspend;
  wire susp_done = (cnt == CNT_W'(SUSP_DELAY_CYC - 1));
  wire resume_done = (cnt == CNT_W'(RESUME_DELAY_CYC - 1));

  // Next state and delay counter
  always_comb begin
    next_state = state;
    next_cnt = cnt + CNT_W'(1);
    case (state)
      CLS_AWAKE: begin
        next_cnt = '0;
        if (go_suspend_fall) begin
          next_state = CLS_ENTERING;
        end
      end
      CLS_ENTERING: begin
        if (wake_rise) begin
          next_state = CLS_AWAKE;
        end else if (susp_done) begin
          next_state = CLS_SUSPENDED;
          next_cnt = '0;
        end
      end
      CLS_SUSPENDED: begin
        next_cnt = '0;
        if (wake_rise) begin
          next_state = CLS_RESUMING;
        end
      end
      CLS_RESUMING: begin
        if (resume_done) begin
          next_state = CLS_AWAKE;
          next_cnt = '0;
        end
      end
      default: begin
        next_state = CLS_AWAKE;
        next_cnt = '0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= CLS_AWAKE;
      cnt <= '0;
      go_suspend_prev <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      go_suspend_prev <= go_suspend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator, PLL and clock source control

  // Oscillator and PLL run while the run bit is set, unless suspended; resume starts them early
  wire osc_allowed = (state != CLS_SUSPENDED) && dev_hw_config_reg.osc_run;
  wire normal_ok = (state == CLS_AWAKE || state == CLS_ENTERING) && dev_hw_config_reg.osc_run;
  wire in_susp = (state == CLS_SUSPENDED || state == CLS_RESUMING);

  // Requested source for the output selector
  assign req_src = normal_ok ? CLS_SRC_NORMAL :
                   (in_susp && !dev_hw_config_reg.slow_clk_disable) ? CLS_SRC_SLOW :
                   CLS_SRC_OFF;

  // Power controls and status outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_enable <= 1'b0;
      pll_enable <= 1'b0;
      osc_out <= 1'b0;
      dev_suspend <= 1'b0;
    end else begin
      osc_enable <= osc_allowed;
      pll_enable <= osc_allowed;
      osc_out <= osc_allowed && !osc_s2;
      dev_suspend <= (next_state == CLS_SUSPENDED);
    end
  end

  // Divided clock, half period of divider plus one system-clock cycles
  wire [4:0] norm_half = {1'b0, dev_hw_config_reg.clk_out_divider} + 5'h01;

  cls_div #(.W(5)) u_norm_div (
    .clk(clk),
    .reset(reset),
    .run(cur_src == CLS_SRC_NORMAL),
    .half(norm_half),
    .q(norm_q)
  );

  // Slow suspend clock, running only while it is the current source
  cls_div #(.W(8)) u_slow_div (
    .clk(clk),
    .reset(reset),
    .run(cur_src == CLS_SRC_SLOW),
    .half(8'(`CLS_SLOW_HALF_CYC)),
    .q(slow_q)
  );

  cls_clk_mux u_mux (
    .clk(clk),
    .reset(reset),
    .req(req_src),
    .norm_q(norm_q),
    .slow_q(slow_q),
    .cur(cur_src),
    .out(clock_output_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_entry_done;
    state == CLS_ENTERING && susp_done && !wake_rise;
  endsequence

  sequence s_wake_in_susp;
    state == CLS_SUSPENDED && wake_rise;
  endsequence

  sequence s_resume_end;
    state == CLS_RESUMING && resume_done;
  endsequence

  // Suspend entry and exit timing
  a_susp_entry_delay: assert property (s_entry_done |=> dev_suspend && state == CLS_SUSPENDED)
    else $error("suspend not reached at end of entry delay");
  a_susp_not_early: assert property ($rose(dev_suspend) |-> $past(cnt) == CNT_W'(SUSP_DELAY_CYC - 1))
    else $error("suspend output rose before the entry delay");
  a_wake_clears: assert property (s_wake_in_susp |=> !dev_suspend ##0 state == CLS_RESUMING)
    else $error("wake pulse did not clear suspend");
  a_resume_wait: assert property (s_resume_end |=> state == CLS_AWAKE)
    else $error("resume delay not ended on time");
  a_entry_counts: assert property (state == CLS_ENTERING && !wake_rise && !susp_done
      |=> state == CLS_ENTERING && cnt == $past(cnt) + CNT_W'(1))
    else $error("entry delay counter did not advance");
  a_wake_cancel: assert property (state == CLS_ENTERING && wake_rise
      |=> state == CLS_AWAKE && !dev_suspend)
    else $error("wake during entry did not cancel suspend");
  a_suspend_holds: assert property (state == CLS_SUSPENDED && !wake_rise
      |=> state == CLS_SUSPENDED)
    else $error("suspend left without a wake pulse");
  a_resume_holds: assert property (state == CLS_RESUMING && !resume_done
      |=> state == CLS_RESUMING)
    else $error("resume delay cut short");
  a_awake_holds: assert property (state == CLS_AWAKE && !go_suspend_fall
      |=> state == CLS_AWAKE)
    else $error("awake state left without a suspend request");

  // Oscillator, PLL and status
  a_osc_off_susp: assert property (state == CLS_SUSPENDED |=> !osc_enable && !pll_enable)
    else $error("oscillator or PLL on in suspend");
  a_osc_run_ctrl: assert property (!dev_hw_config_reg.osc_run |=> !osc_enable)
    else $error("oscillator on with run bit clear");
  a_go_suspend_start: assert property (state == CLS_AWAKE && go_suspend_fall |=> state == CLS_ENTERING)
    else $error("go_suspend set-and-clear did not start suspend");
  a_bus_status: assert property (rd_any && hit_stat |=> prdata[`CLS_STAT_BUS_SUSP_BIT] == $past(dev_suspend))
    else $error("bus suspend status read wrong");
  a_osc_resume: assert property (state == CLS_RESUMING && dev_hw_config_reg.osc_run
      |=> osc_enable && pll_enable)
    else $error("oscillator or PLL off during resume");
  a_status_level: assert property (dev_suspend == (state == CLS_SUSPENDED))
    else $error("suspend output disagrees with suspend state");
  a_ref_timeout: assert property ($fell(ref_active) |-> $past(ref_timer) == 8'h00)
    else $error("reference presence dropped before its timeout");

  // Clock source and register writes
  a_slow_toggles: assert property ($rose(state == CLS_SUSPENDED)
      && !dev_hw_config_reg.slow_clk_disable |-> ##[1:300] clock_output_pin)
    else $error("slow clock absent in suspend");
  a_normal_leaves: assert property ($rose(state == CLS_SUSPENDED) |-> ##[1:40] cur_src != CLS_SRC_NORMAL)
    else $error("normal clock still selected in suspend");
  a_static_low: assert property (in_susp && dev_hw_config_reg.slow_clk_disable
      && cur_src == CLS_SRC_OFF |=> !clock_output_pin)
    else $error("clock output moved with slow clock disabled");
  a_cfg_write: assert property (wr_cfg |=> {dev_hw_config_reg} == $past(pwdata[5:0]))
    else $error("configuration write not stored");
endmodule

// [tb/cls_far_model.sv]
// Far-side model: external reference source and wake-up source
// Assumes clk is the device system clock; wake changes just after its rising edge
`timescale 1ns/1ps
module cls_far_model (
  input wire logic clk,
  input wire logic osc_enable,
  output logic osc_in,
  output logic dev_wake_in
);
  ////////////////////////////////////////////////////////////////////////////////
  // Square-wave reference near 6 MHz, stands low while oscillator is off
  initial osc_in = 1'b0;
  always begin
    #83.333;
    osc_in = (osc_enable === 1'b1) ? ~osc_in : 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Positive wake pulse lasting n clock cycles
  initial dev_wake_in = 1'b0;
  task automatic pulse_wake(input int n);
    @(posedge clk);
    dev_wake_in <= 1'b1;
    repeat (n) @(posedge clk);
    dev_wake_in <= 1'b0;
  endtask
endmodule

// [tb/tb.sv]
// Testbench: registers, clock output rates, suspend entry and resume
// Assumes the package, design files and far-side model are compiled first
`timescale 1ns/1ps
`include "cls_map.svh"
module tb;
  import cls_pkg::*;
  localparam int SUSP = 40;
  localparam int RES = 20;
  localparam int SLOW = `CLS_SLOW_HALF_CYC;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] mask;
    logic [31:0] exp;
    logic err;
  } cls_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic pready, pslverr, osc_in, osc_out, dev_wake_in, clock_output_pin;
  logic dev_suspend, osc_enable, pll_enable, err;
  logic [31:0] prdata, rd;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  int divs [3] = '{0, 3, 15};
  cls_row_t rows [8] = '{
    '{1'b0, 12'h000, 32'h0, 32'hFFFFFFFF, 32'h13, 1'b0},
    '{1'b1, 12'h000, 32'hFFFFFFF5, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h000, 32'h0, 32'hFFFFFFFF, 32'h35, 1'b0},
    '{1'b1, 12'h000, 32'h13, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'hFFFFFFFF, 32'h1, 1'b0},
    '{1'b0, 12'h00C, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1},
    '{1'b1, 12'h010, 32'h5, 32'h0, 32'h0, 1'b1}
  };
  // 25 MHz clock
  always #20 clk = ~clk;
  cls_top #(.SUSP_DELAY_CYC(SUSP), .RESUME_DELAY_CYC(RES)) cls_top_i (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .osc_in(osc_in), .osc_out(osc_out),
    .dev_wake_in(dev_wake_in), .clock_output_pin(clock_output_pin),
    .dev_suspend(dev_suspend), .osc_enable(osc_enable), .pll_enable(pll_enable));
  cls_far_model cls_far_model_i (.clk(clk), .osc_enable(osc_enable),
    .osc_in(osc_in), .dev_wake_in(dev_wake_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cycles until suspend output (0) or clock output (1) reaches v
  task automatic wait_for(input int which, input logic v, output int c);
    c = 0;
    while ((which == 0 ? dev_suspend : clock_output_pin) !== v) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic high_len(output int c);
    int k;
    wait_for(1, 1'b0, k);
    wait_for(1, 1'b1, k);
    wait_for(1, 1'b0, c);
  endtask
  task automatic count_rises(input int len, output int c);
    logic last;
    c = 0;
    last = clock_output_pin;
    repeat (len) begin
      @(posedge clk);
      if (clock_output_pin === 1'b1 && last !== 1'b1) c++;
      last = clock_output_pin;
    end
  endtask
  task automatic go_susp();
    apb(1'b1, `CLS_MODE_ADDR, 32'h1, rd, err);
    apb(1'b1, `CLS_MODE_ADDR, 32'h0, rd, err);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("timeout reached");
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    chk("suspend in reset", 32'h0, {31'h0, dev_suspend});
    chk("clock in reset", 32'h0, {31'h0, clock_output_pin});
    reset <= 1'b0;
    repeat (80) @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, err);
      chk("register data", rows[i].exp, rd & rows[i].mask);
      chk("slave error", {31'h0, rows[i].err}, {31'h0, err});
    end
    $display("register table test done");
    foreach (divs[i]) begin
      apb(1'b1, `CLS_HW_CFG_ADDR, 32'h10 | divs[i], rd, err);
      high_len(n);
      high_len(n);
      chk_rng("normal half period", divs[i] + 1, divs[i] + 1, n);
    end
    $display("divider test done");
    apb(1'b1, `CLS_HW_CFG_ADDR, 32'h03, rd, err);
    // Let the selector finish its last normal pulse before counting
    repeat (40) @(posedge clk);
    count_rises(40, n);
    chk_rng("rises with oscillator off", 0, 0, n);
    chk("oscillator off", 32'h0, {30'h0, osc_enable, pll_enable});
    chk("oscillator drive off", 32'h0, {31'h0, osc_out});
    apb(1'b0, `CLS_STATUS_ADDR, 32'h0, rd, err);
    chk("reference gone", 32'h0, rd & 32'h1);
    apb(1'b1, `CLS_HW_CFG_ADDR, 32'h13, rd, err);
    repeat (4) @(posedge clk);
    chk("oscillator on", 32'h3, {30'h0, osc_enable, pll_enable});
    $display("oscillator control test done");
    go_susp();
    wait_for(0, 1'b1, n);
    chk_rng("entry delay", SUSP - 2, SUSP + 3, n);
    repeat (3) @(posedge clk);
    chk("oscillator and pll", 32'h0, {29'h0, osc_enable, pll_enable, osc_out});
    apb(1'b0, `CLS_STATUS_ADDR, 32'h0, rd, err);
    chk("suspend status", 32'h80, rd & 32'h80);
    high_len(n);
    high_len(n);
    chk_rng("slow half period", SLOW, SLOW, n);
    cls_far_model_i.pulse_wake(4);
    wait_for(0, 1'b0, n);
    chk_rng("wake to awake", 0, 6, n);
    // Oscillator enable is launched one edge after the suspend output clears
    @(posedge clk);
    chk("oscillator after wake", 32'h3, {30'h0, osc_enable, pll_enable});
    wait_for(1, 1'b1, n);
    chk_rng("restart delay", RES - 2, RES + SLOW + 10, n);
    high_len(n);
    chk_rng("half period after resume", 4, 4, n);
    apb(1'b0, `CLS_STATUS_ADDR, 32'h0, rd, err);
    chk("awake status", 32'h0, rd & 32'h80);
    $display("slow suspend test done");
    apb(1'b1, `CLS_HW_CFG_ADDR, 32'h33, rd, err);
    go_susp();
    wait_for(0, 1'b1, n);
    // Let the last normal pulse end before counting
    repeat (10) @(posedge clk);
    count_rises(300, n);
    chk_rng("rises with slow clock off", 0, 0, n);
    cls_far_model_i.pulse_wake(4);
    wait_for(0, 1'b0, n);
    wait_for(1, 1'b1, n);
    chk_rng("restart after static", RES - 2, RES + 10, n);
    apb(1'b1, `CLS_HW_CFG_ADDR, 32'h13, rd, err);
    $display("static suspend test done");
    go_susp();
    repeat (10) @(posedge clk);
    cls_far_model_i.pulse_wake(4);
    repeat (SUSP + 10) @(posedge clk);
    chk("cancelled entry", 32'h0, {31'h0, dev_suspend});
    $display("cancel test done");
    go_susp();
    wait_for(0, 1'b1, n);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    chk("suspend after reset", 32'h0, {31'h0, dev_suspend});
    reset <= 1'b0;
    apb(1'b0, `CLS_HW_CFG_ADDR, 32'h0, rd, err);
    chk("config after reset", 32'h13, rd);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule
